// ==== rtl/aiocfg_pkg.sv ====
// How it works
// - three switches pick one range for all
// - small module decodes unipolar or bipolar ranges
// - six switches set range for all channels
// - switch six on means unipolar, off bipolar
// - switches four, five pick gain; both invalid
// - switches one to three pick attenuation
// - full six-switch pattern maps to one range
// - result left-justified, sign bit on top
// - unipolar word pads three low zeros
// - bipolar word pads four low zeros
// - output word drops four low bits
// - each access starts a fresh conversion
// - raw result, no filtering or linearization
// - full-scale input calibrates to word 32000
package aiocfg_pkg;

  // clock rate and conversion time
  localparam int unsigned CLK_MHZ       = 125;
  localparam int unsigned CONV_TIME_US  = 149;
  // least time, exact whole cycles at this rate
  localparam int unsigned CONV_CYCLES   = CONV_TIME_US * CLK_MHZ;
  localparam int unsigned CONV_CNT_W    = 16;

  // word layout
  localparam int unsigned WORD_W        = 16;
  localparam int unsigned ADC_W         = 12;
  localparam int unsigned UNI_PAD_W     = 3;
  localparam int unsigned BI_PAD_W      = 4;
  localparam int unsigned DAC_LSB       = 4;
  localparam int unsigned CHAN_W        = 2;
  localparam int unsigned FIFO_DEPTH    = 16;
  localparam int unsigned FIFO_W        = CHAN_W + WORD_W;

  // calibrated full-scale word, analog trim only
  localparam logic [WORD_W-1:0] FULL_SCALE_WORD = 16'h7D00;

  // reset values
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [ADC_W-1:0]  DAC_RST   = 12'h000;

  // full-scale input ranges of both module kinds
  typedef enum logic [4:0] {
    AIOCFG_RNG_NONE,
    AIOCFG_RNG_U50MV,
    AIOCFG_RNG_U100MV,
    AIOCFG_RNG_U500MV,
    AIOCFG_RNG_U1V,
    AIOCFG_RNG_U5V_20MA,
    AIOCFG_RNG_U10V,
    AIOCFG_RNG_B25MV,
    AIOCFG_RNG_B50MV,
    AIOCFG_RNG_B100MV,
    AIOCFG_RNG_B250MV,
    AIOCFG_RNG_B500MV,
    AIOCFG_RNG_B1V,
    AIOCFG_RNG_B2V5,
    AIOCFG_RNG_B5V,
    AIOCFG_RNG_B10V
  } aiocfg_range_t;

  // amplifier gain selection
  typedef enum logic [1:0] {
    AIOCFG_GAIN_X1,
    AIOCFG_GAIN_X10,
    AIOCFG_GAIN_X100,
    AIOCFG_GAIN_BAD
  } aiocfg_gain_t;

  // input attenuation selection
  typedef enum logic [1:0] {
    AIOCFG_ATT_0P8,
    AIOCFG_ATT_0P4,
    AIOCFG_ATT_0P2,
    AIOCFG_ATT_BAD
  } aiocfg_atten_t;

  // conversion sequencer
  typedef enum logic {
    AIOCFG_ST_IDLE,
    AIOCFG_ST_CONV
  } aiocfg_state_t;

endpackage

// ==== rtl/aiocfg_fifo.sv ====
// result buffer with registered read data
module aiocfg_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_b_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
  localparam logic [PTR_W-1:0] PTR_ONE  = PTR_W'(1);

  logic [WIDTH-1:0] mem [DEPTH];        // storage words
  logic [PTR_W-1:0] wr_ptr_ff;          // next write slot
  logic [PTR_W-1:0] rd_ptr_ff;          // next read slot
  logic [CNT_W-1:0] cnt_ff;             // words held in storage
  logic             out_valid_ff;       // output register full
  logic [WIDTH-1:0] out_data_ff;        // output register
  logic             push;               // accepted write
  logic             pop;                // move storage to output

  // full counts storage only; output stage is extra slack
  assign in_ready_out  = (cnt_ff != CNT_FULL);
  assign push          = in_valid_in && in_ready_out;
  assign pop           = (cnt_ff != '0) && (!out_valid_ff || out_ready_in);
  assign out_valid_out = out_valid_ff;
  assign out_data_out  = out_data_ff;

  // storage write, no reset needed on data
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data_in;
    end
  end

  // pointers and fill level
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + PTR_ONE;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + PTR_ONE;
      end
      // simultaneous push and pop leave level alone
      if (push && !pop) begin
        cnt_ff <= cnt_ff + CNT_ONE;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - CNT_ONE;
      end
    end
  end

  // registered read stage
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      out_valid_ff <= 1'b0;
      out_data_ff  <= '0;
    end else if (pop) begin
      out_valid_ff <= 1'b1;
      out_data_ff  <= mem[rd_ptr_ff];
    end else if (out_ready_in) begin
      out_valid_ff <= 1'b0;
    end
  end

endmodule

// ==== rtl/aiocfg_top.sv ====
// analog module digital side: switch decode, word packing, dac load
module aiocfg_top #(
  parameter int unsigned CONV_CYCLES = aiocfg_pkg::CONV_CYCLES
) (
  input  wire logic                             mclk_in,
  input  wire logic                             rst_b_in,
  // module kind: 0 small input, 1 combined in/out
  input  wire logic                             combined_sel_in,
  // configuration switches, 1 = closed (ON)
  input  wire logic                             config_switch_one_in,
  input  wire logic                             config_switch_two_in,
  input  wire logic                             config_switch_three_in,
  input  wire logic                             gain_switch_low_in,
  input  wire logic                             gain_switch_high_in,
  input  wire logic                             polarity_switch_in,
  // decoded configuration
  output aiocfg_pkg::aiocfg_range_t             range_out,
  output aiocfg_pkg::aiocfg_gain_t              gain_out,
  output aiocfg_pkg::aiocfg_atten_t             atten_out,
  output logic                                  bipolar_out,
  output logic                                  cfg_error_out,
  // cpu access to an analog input point
  input  wire logic                             acc_req_in,
  input  wire logic [aiocfg_pkg::CHAN_W-1:0]    acc_chan_in,
  output logic                                  acc_ready_out,
  output logic                                  busy_out,
  // converter side
  output logic                                  adc_start_out,
  output logic      [aiocfg_pkg::CHAN_W-1:0]    adc_chan_out,
  input  wire logic [aiocfg_pkg::ADC_W-1:0]     adc_data_in,
  // input words toward the cpu
  output logic                                  rd_valid_out,
  input  wire logic                             rd_ready_in,
  output logic      [aiocfg_pkg::WORD_W-1:0]    rd_word_out,
  output logic      [aiocfg_pkg::CHAN_W-1:0]    rd_chan_out,
  // output word from the cpu
  input  wire logic                             dac_wr_in,
  input  wire logic [aiocfg_pkg::WORD_W-1:0]    dac_word_in,
  output logic                                  dac_load_out,
  output logic      [aiocfg_pkg::ADC_W-1:0]     dac_data_out
);

  localparam logic [aiocfg_pkg::CONV_CNT_W-1:0] CONV_LAST =
    aiocfg_pkg::CONV_CNT_W'(CONV_CYCLES - 1);
  localparam logic [aiocfg_pkg::CONV_CNT_W-1:0] CNT_ONE =
    aiocfg_pkg::CONV_CNT_W'(1);

  // small module: switches one..three only
  function automatic aiocfg_pkg::aiocfg_range_t small_range(
    input logic [2:0] sw
  );
    aiocfg_pkg::aiocfg_range_t r;
    r = aiocfg_pkg::AIOCFG_RNG_NONE;
    case (sw)
      3'h5:    r = aiocfg_pkg::AIOCFG_RNG_U10V;
      3'h6:    r = aiocfg_pkg::AIOCFG_RNG_U5V_20MA;
      3'h1:    r = aiocfg_pkg::AIOCFG_RNG_B5V;
      3'h2:    r = aiocfg_pkg::AIOCFG_RNG_B2V5;
      default: r = aiocfg_pkg::AIOCFG_RNG_NONE;
    endcase
    return r;
  endfunction

  // combined module: all six switches, switch one on top
  function automatic aiocfg_pkg::aiocfg_range_t comb_range(
    input logic [5:0] sw
  );
    aiocfg_pkg::aiocfg_range_t r;
    r = aiocfg_pkg::AIOCFG_RNG_NONE;
    case (sw)
      6'h25:   r = aiocfg_pkg::AIOCFG_RNG_U50MV;
      6'h15:   r = aiocfg_pkg::AIOCFG_RNG_U100MV;
      6'h23:   r = aiocfg_pkg::AIOCFG_RNG_U500MV;
      6'h13:   r = aiocfg_pkg::AIOCFG_RNG_U1V;
      // 0..5 V and 0..20 mA share one setting
      6'h21:   r = aiocfg_pkg::AIOCFG_RNG_U5V_20MA;
      6'h11:   r = aiocfg_pkg::AIOCFG_RNG_U10V;
      6'h24:   r = aiocfg_pkg::AIOCFG_RNG_B25MV;
      6'h14:   r = aiocfg_pkg::AIOCFG_RNG_B50MV;
      6'h0C:   r = aiocfg_pkg::AIOCFG_RNG_B100MV;
      6'h22:   r = aiocfg_pkg::AIOCFG_RNG_B250MV;
      6'h12:   r = aiocfg_pkg::AIOCFG_RNG_B500MV;
      6'h0A:   r = aiocfg_pkg::AIOCFG_RNG_B1V;
      6'h20:   r = aiocfg_pkg::AIOCFG_RNG_B2V5;
      6'h10:   r = aiocfg_pkg::AIOCFG_RNG_B5V;
      6'h08:   r = aiocfg_pkg::AIOCFG_RNG_B10V;
      default: r = aiocfg_pkg::AIOCFG_RNG_NONE;
    endcase
    return r;
  endfunction

  // gain from switches four and five
  function automatic aiocfg_pkg::aiocfg_gain_t gain_dec(
    input logic [1:0] sw
  );
    aiocfg_pkg::aiocfg_gain_t g;
    g = aiocfg_pkg::AIOCFG_GAIN_BAD;
    case (sw)
      2'h0:    g = aiocfg_pkg::AIOCFG_GAIN_X1;
      2'h1:    g = aiocfg_pkg::AIOCFG_GAIN_X10;
      2'h2:    g = aiocfg_pkg::AIOCFG_GAIN_X100;
      default: g = aiocfg_pkg::AIOCFG_GAIN_BAD;
    endcase
    return g;
  endfunction

  // attenuation, exactly one of switches one..three on
  function automatic aiocfg_pkg::aiocfg_atten_t atten_dec(
    input logic [2:0] sw
  );
    aiocfg_pkg::aiocfg_atten_t a;
    a = aiocfg_pkg::AIOCFG_ATT_BAD;
    case (sw)
      3'h4:    a = aiocfg_pkg::AIOCFG_ATT_0P8;
      3'h2:    a = aiocfg_pkg::AIOCFG_ATT_0P4;
      3'h1:    a = aiocfg_pkg::AIOCFG_ATT_0P2;
      default: a = aiocfg_pkg::AIOCFG_ATT_BAD;
    endcase
    return a;
  endfunction

  logic [2:0] sw_att;                       // switches one..three
  logic [1:0] sw_gain;                      // switches four, five
  logic [5:0] sw_all;                       // all six, one on top

  aiocfg_pkg::aiocfg_range_t nxt_range;     // decoded range
  aiocfg_pkg::aiocfg_gain_t  nxt_gain;      // decoded gain
  aiocfg_pkg::aiocfg_atten_t nxt_atten;     // decoded attenuation
  logic                      nxt_bipolar;   // decoded polarity
  logic                      nxt_cfg_err;   // decoded error

  aiocfg_pkg::aiocfg_range_t range_ff;      // registered range
  aiocfg_pkg::aiocfg_gain_t  gain_ff;       // registered gain
  aiocfg_pkg::aiocfg_atten_t atten_ff;      // registered attenuation
  logic                      bipolar_ff;    // registered polarity
  logic                      cfg_err_ff;    // registered error

  aiocfg_pkg::aiocfg_state_t state_ff;      // sequencer state
  logic [aiocfg_pkg::CONV_CNT_W-1:0] conv_cnt_ff; // conversion timer
  logic [aiocfg_pkg::CHAN_W-1:0]     chan_ff;     // channel in flight
  logic                              start_ff;    // converter kick
  logic                              conv_done;   // timer expired
  logic [aiocfg_pkg::WORD_W-1:0]     nxt_word;    // packed input word

  logic                              fifo_in_valid; // push result
  logic                              fifo_in_ready; // room for result
  logic [aiocfg_pkg::FIFO_W-1:0]     fifo_out_data; // buffered word

  logic                              dac_load_ff; // dac load strobe
  logic [aiocfg_pkg::ADC_W-1:0]      dac_data_ff; // dac code

  assign sw_att  = {config_switch_one_in, config_switch_two_in,
                    config_switch_three_in};
  assign sw_gain = {gain_switch_low_in, gain_switch_high_in};
  assign sw_all  = {sw_att, sw_gain, polarity_switch_in};

  // switch decode for the selected module kind
  always_comb begin
    nxt_range   = aiocfg_pkg::AIOCFG_RNG_NONE;
    nxt_gain    = aiocfg_pkg::AIOCFG_GAIN_X1;
    nxt_atten   = aiocfg_pkg::AIOCFG_ATT_0P8;
    nxt_bipolar = 1'b0;
    nxt_cfg_err = 1'b0;
    if (combined_sel_in) begin
      nxt_range   = comb_range(sw_all);
      nxt_bipolar = !polarity_switch_in;
      nxt_gain    = gain_dec(sw_gain);
      nxt_atten   = atten_dec(sw_att);
      nxt_cfg_err = (nxt_gain == aiocfg_pkg::AIOCFG_GAIN_BAD) ||
                    (nxt_atten == aiocfg_pkg::AIOCFG_ATT_BAD);
    end else begin
      nxt_range   = small_range(sw_att);
      nxt_bipolar = !config_switch_one_in;
      nxt_cfg_err = (nxt_range == aiocfg_pkg::AIOCFG_RNG_NONE);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      range_ff   <= aiocfg_pkg::AIOCFG_RNG_NONE;
      gain_ff    <= aiocfg_pkg::AIOCFG_GAIN_X1;
      atten_ff   <= aiocfg_pkg::AIOCFG_ATT_0P8;
      bipolar_ff <= 1'b0;
      cfg_err_ff <= 1'b0;
    end else begin
      // switches are slow; sampling every cycle is enough
      range_ff   <= nxt_range;
      gain_ff    <= nxt_gain;
      atten_ff   <= nxt_atten;
      bipolar_ff <= nxt_bipolar;
      cfg_err_ff <= nxt_cfg_err;
    end
  end

  assign range_out     = range_ff;
  assign gain_out      = gain_ff;
  assign atten_out     = atten_ff;
  assign bipolar_out   = bipolar_ff;
  assign cfg_error_out = cfg_err_ff;

  // accept only when idle and the buffer can take the result
  assign acc_ready_out = (state_ff == aiocfg_pkg::AIOCFG_ST_IDLE) &&
                         fifo_in_ready;
  assign busy_out      = (state_ff == aiocfg_pkg::AIOCFG_ST_CONV);
  assign conv_done     = (state_ff == aiocfg_pkg::AIOCFG_ST_CONV) &&
                         (conv_cnt_ff == CONV_LAST);
  // a full buffer stalls the end of conversion, not the data
  assign fifo_in_valid = conv_done;

  // conversion sequencer
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      state_ff <= aiocfg_pkg::AIOCFG_ST_IDLE;
    end else begin
      case (state_ff)
        aiocfg_pkg::AIOCFG_ST_IDLE: begin
          if (acc_req_in && acc_ready_out) begin
            state_ff <= aiocfg_pkg::AIOCFG_ST_CONV;
          end
        end
        aiocfg_pkg::AIOCFG_ST_CONV: begin
          if (conv_done && fifo_in_ready) begin
            state_ff <= aiocfg_pkg::AIOCFG_ST_IDLE;
          end
        end
        default: begin
          state_ff <= aiocfg_pkg::AIOCFG_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      conv_cnt_ff <= '0;
    end else if (state_ff == aiocfg_pkg::AIOCFG_ST_IDLE) begin
      conv_cnt_ff <= '0;
    end else if (!conv_done) begin
      conv_cnt_ff <= conv_cnt_ff + CNT_ONE;
    end
  end

  // channel capture and converter start strobe
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      chan_ff  <= '0;
      start_ff <= 1'b0;
    end else begin
      start_ff <= 1'b0;
      if ((state_ff == aiocfg_pkg::AIOCFG_ST_IDLE) && acc_req_in &&
          acc_ready_out) begin
        chan_ff  <= acc_chan_in;
        start_ff <= 1'b1;
      end
    end
  end

  assign adc_start_out = start_ff;
  assign adc_chan_out  = chan_ff;

  // word packing for the cpu
  always_comb begin
    nxt_word = aiocfg_pkg::WORD_ZERO;
    if (cfg_err_ff) begin
      nxt_word = aiocfg_pkg::WORD_ZERO;
    end else if (bipolar_ff) begin
      nxt_word = {adc_data_in, {aiocfg_pkg::BI_PAD_W{1'b0}}};
    end else begin
      nxt_word = {1'b0, adc_data_in, {aiocfg_pkg::UNI_PAD_W{1'b0}}};
    end
  end
  // full-scale 32000 comes from analog trim, not scaling
  // averaging, if wanted, is left to the controller program

  aiocfg_fifo #(
    .WIDTH (aiocfg_pkg::FIFO_W),
    .DEPTH (aiocfg_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk_in       (mclk_in),
    .rst_b_in      (rst_b_in),
    .in_valid_in   (fifo_in_valid),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    ({chan_ff, nxt_word}),
    .out_valid_out (rd_valid_out),
    .out_ready_in  (rd_ready_in),
    .out_data_out  (fifo_out_data)
  );

  assign rd_word_out = fifo_out_data[aiocfg_pkg::WORD_W-1:0];
  assign rd_chan_out = fifo_out_data[aiocfg_pkg::FIFO_W-1:
                                     aiocfg_pkg::WORD_W];

  // output word load into the dac
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      dac_load_ff <= 1'b0;
      dac_data_ff <= aiocfg_pkg::DAC_RST;
    end else begin
      dac_load_ff <= dac_wr_in;
      if (dac_wr_in) begin
        dac_data_ff <= dac_word_in[aiocfg_pkg::WORD_W-1:
                                   aiocfg_pkg::DAC_LSB];
      end
    end
  end

  assign dac_load_out = dac_load_ff;
  assign dac_data_out = dac_data_ff;

endmodule

// ==== verification/aiocfg_props.sv ====
module aiocfg_props #(
  parameter int unsigned CONV_CYCLES = 8
) (
  input wire logic        mclk_in,
  input wire logic        rst_b_in,
  input wire logic        combined_sel_in,
  input wire logic        gain_switch_low_in,
  input wire logic        gain_switch_high_in,
  input wire logic        polarity_switch_in,
  input wire logic        acc_req_in,
  input wire logic [1:0]  acc_chan_in,
  input wire logic        acc_ready_out,
  input wire logic        busy_out,
  input wire logic        adc_start_out,
  input wire logic [1:0]  adc_chan_out,
  input wire logic        rd_valid_out,
  input wire logic        rd_ready_in,
  input wire logic [15:0] rd_word_out,
  input wire logic [1:0]  rd_chan_out,
  input wire logic        dac_wr_in,
  input wire logic [15:0] dac_word_in,
  input wire logic        dac_load_out,
  input wire logic [11:0] dac_data_out,
  input wire logic        bipolar_out,
  input wire logic        cfg_error_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  logic [15:0] left_ff;  // conversion cycles left
  // counter, not a long repetition
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      left_ff <= 16'h0000;
    end else if (adc_start_out) begin
      left_ff <= 16'(CONV_CYCLES - 2);
    end else if (left_ff != 16'h0000) begin
      left_ff <= left_ff - 16'h0001;
    end
  end
  property p_take;
    acc_req_in && acc_ready_out |=>
      adc_start_out && adc_chan_out == $past(acc_chan_in);
  endproperty
  a_take: assert property (p_take) else $error("no start after take");
  property p_refused;
    !(acc_req_in && acc_ready_out) |=> !adc_start_out;
  endproperty
  a_refused: assert property (p_refused) else $error("stray start");
  property p_busy;
    adc_start_out || left_ff != 16'h0000 |-> busy_out && !acc_ready_out;
  endproperty
  a_busy: assert property (p_busy) else $error("conversion cut short");
  property p_rd_hold;
    rd_valid_out && !rd_ready_in |=>
      rd_valid_out && $stable(rd_word_out) && $stable(rd_chan_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("word dropped");
  property p_pad;
    rd_valid_out |-> rd_word_out[2:0] == 3'h0;
  endproperty
  a_pad: assert property (p_pad) else $error("low bits not zero");
  property p_dac_load;
    dac_wr_in |=> dac_load_out && dac_data_out == $past(dac_word_in[15:4]);
  endproperty
  a_dac_load: assert property (p_dac_load) else $error("bad load");
  property p_dac_idle;
    !dac_wr_in |=> !dac_load_out && $stable(dac_data_out);
  endproperty
  a_dac_idle: assert property (p_dac_idle) else $error("stray load");
  property p_pol;
    combined_sel_in && $past(combined_sel_in) && $past(rst_b_in) |->
      bipolar_out == !$past(polarity_switch_in);
  endproperty
  a_pol: assert property (p_pol) else $error("polarity wrong");
  property p_gain_bad;
    combined_sel_in && $past(combined_sel_in) && $past(rst_b_in) &&
      $past(gain_switch_low_in) && $past(gain_switch_high_in) |->
      cfg_error_out;
  endproperty
  a_gain_bad: assert property (p_gain_bad) else $error("no gain error");
  c_take: cover property (acc_req_in && acc_ready_out);
  c_full: cover property (rd_valid_out && !rd_ready_in && busy_out);
  c_dac: cover property (dac_wr_in ##1 dac_wr_in);
  c_err: cover property (cfg_error_out && combined_sel_in);
endmodule

bind aiocfg_top aiocfg_props #(.CONV_CYCLES(CONV_CYCLES)) u_props (.*);

// ==== verification/aiocfg_adc_model.sv ====
// converter and reading controller on the far side of the block
module aiocfg_adc_model #(
  parameter logic [31:0] SEED = 32'h1F3D5B79
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  input  wire logic        start_in,
  input  wire logic        stall_in,
  output logic      [11:0] adc_data_out,
  output logic             rd_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] st_ff;  // free-running noise source
  // raw samples
  // every start yields a new unfiltered sample, held until the next one
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      st_ff        <= SEED;
      adc_data_out <= 12'h000;
    end else begin
      st_ff <= st_ff ^ (st_ff << 13) ^ ((st_ff ^ (st_ff << 13)) >> 17);
      if (start_in) begin
        adc_data_out <= st_ff[11:0];
      end
    end
  end
  // averaging left to reader; takes raw words at random
  assign rd_ready_out = !stall_in && st_ff[20];
endmodule

// ==== verification/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned CONV = 8;  // short conversion for simulation
  logic        mclk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        comb = 1'b0;       // module kind
  logic [5:0]  sw = 6'h00;        // {one,two,three,low,high,polarity}
  logic        req = 1'b0;
  logic [1:0]  chan = 2'h0;
  logic        dac_wr = 1'b0;
  logic [15:0] dac_word = 16'h0000;
  logic        stall = 1'b0;      // holds the reader off
  aiocfg_pkg::aiocfg_range_t rng_o;
  aiocfg_pkg::aiocfg_gain_t  gain_o;
  aiocfg_pkg::aiocfg_atten_t att_o;
  logic        bip_o, err_o, ready_o, busy_o, start_o, rd_valid_o;
  logic        rd_ready, load_o;
  logic [1:0]  achan_o, rchan_o;
  logic [11:0] adc_d, dacd_o;
  logic [15:0] word_o;
  logic [31:0] seed = 32'hBA2A702C;
  int          fail_count = 0;
  int          tests_run = 0;
  logic [17:0] expq[$];           // expected {chan, word} in order
  logic        pend = 1'b0;
  logic [1:0]  pchan = 2'h0;

  always #4 mclk_in = ~mclk_in;

  aiocfg_top #(.CONV_CYCLES(CONV)) dut (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .combined_sel_in(comb),
    .config_switch_one_in(sw[5]), .config_switch_two_in(sw[4]),
    .config_switch_three_in(sw[3]), .gain_switch_low_in(sw[2]),
    .gain_switch_high_in(sw[1]), .polarity_switch_in(sw[0]),
    .range_out(rng_o), .gain_out(gain_o), .atten_out(att_o),
    .bipolar_out(bip_o), .cfg_error_out(err_o), .acc_req_in(req),
    .acc_chan_in(chan), .acc_ready_out(ready_o), .busy_out(busy_o),
    .adc_start_out(start_o), .adc_chan_out(achan_o), .adc_data_in(adc_d),
    .rd_valid_out(rd_valid_o), .rd_ready_in(rd_ready),
    .rd_word_out(word_o), .rd_chan_out(rchan_o), .dac_wr_in(dac_wr),
    .dac_word_in(dac_word), .dac_load_out(load_o), .dac_data_out(dacd_o));
  aiocfg_adc_model model (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .start_in(start_o), .stall_in(stall), .adc_data_out(adc_d),
    .rd_ready_out(rd_ready));

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  // attenuation index, 3 if not one-hot
  function automatic int att_ix(input logic [5:0] s);
    case (s[5:3])
      3'b100: return 0;
      3'b010: return 1;
      3'b001: return 2;
      default: return 3;
    endcase
  endfunction
  function automatic logic exp_err(input logic c, input logic [5:0] s);
    if (c) return (s[2:1] == 2'b11) || (att_ix(s) == 3);
    return !(s[5:3] inside {3'b101, 3'b110, 3'b001, 3'b010});
  endfunction
  // range code in enum order
  function automatic logic [4:0] exp_rng(input logic c, input logic [5:0] s);
    int g;
    int a;
    g = 2 - int'(s[2:1]);
    a = att_ix(s);
    if (!c) begin
      case (s[5:3])
        3'b101: return 5'h06;
        3'b110: return 5'h05;
        3'b001: return 5'h0E;
        default: return 5'h0D;
      endcase
    end
    if (s[0]) return (a == 2) ? 5'h00 : 5'(1 + g * 2 + a);
    return 5'(7 + g * 3 + a);
  endfunction
  function automatic logic [15:0] exp_word(input logic [11:0] d,
                                           input logic b, input logic e);
    if (e) return 16'h0000;
    return b ? {d, 4'h0} : {1'b0, d, 3'h0};
  endfunction

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic miss(input string m);
    fail_count++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask
  task automatic check_flag(input logic got, input logic exp, string m);
    tests_run++;
    if (got !== exp) miss(m);
  endtask
  task automatic check_code(input logic [4:0] got, exp, input string m);
    tests_run++;
    if (got !== exp) miss(m);
  endtask
  task automatic check_word(input logic [15:0] got, exp, input string m);
    tests_run++;
    if (got !== exp) miss(m);
  endtask
  // inputs move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic wait_ready(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 60 && !ok; i++) begin
      if (ready_o === 1'b1) ok = 1'b1;
      else tick(1);
    end
  endtask
  task automatic do_access(input logic [1:0] c, output logic ok);
    wait_ready(ok);
    if (ok) begin
      req = 1'b1;
      chan = c;
      tick(1);
      req = 1'b0;
    end
  endtask
  task automatic check_cfg(input logic c, input logic [5:0] s);
    comb = c;
    sw = s;
    tick(2);
    check_flag(err_o, exp_err(c, s), "config error");
    check_flag(bip_o, c ? !s[0] : !s[5], "polarity");
    if (!exp_err(c, s)) check_code(rng_o, exp_rng(c, s), "range");
    if (c && !exp_err(c, s)) begin
      check_code({3'h0, gain_o}, 5'(s[2:1]), "gain");
      check_code({3'h0, att_o}, 5'(att_ix(s)), "attenuation");
    end
  endtask

  // config steady during conversion
  always @(negedge mclk_in) begin
    if (pend) expq.push_back({pchan, exp_word(adc_d, comb ? !sw[0] : !sw[5],
                                              exp_err(comb, sw))});
    pend = rst_b_in && start_o === 1'b1;
    pchan = achan_o;
  end
  // taken words match oldest expectation
  always @(posedge mclk_in) begin
    if (rst_b_in && rd_valid_o === 1'b1 && rd_ready === 1'b1) begin
      if (expq.size() == 0) begin
        check_flag(1'b0, 1'b1, "word without access");
      end else begin
        check_word(word_o, expq[0][15:0], "input word");
        check_code({3'h0, rchan_o}, {3'h0, expq[0][17:16]}, "chan");
        void'(expq.pop_front());
      end
    end
  end

  initial begin
    logic        ok;
    int          taken;
    logic [15:0] w;
    tick(4);
    rst_b_in = 1'b1;
    for (int p = 0; p < 8; p++) begin
      seed = xs(seed);
      check_cfg(1'b0, {p[2:0], seed[2:0]});
    end
    $display("test small module decode done");
    for (int p = 0; p < 64; p++) check_cfg(1'b1, p[5:0]);
    $display("test combined module decode done");
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      wait_ready(ok);
      comb = seed[31];
      sw = seed[29:24];
      tick(2);
      do_access(seed[1:0], ok);
      if (!ok) begin
        miss("access timeout");
        report_and_stop();
      end
      tick(1);
      req = 1'b1;
      tick(1);
      req = 1'b0;
    end
    $display("test conversions done");
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h000F : seed[15:0];
      dac_wr = 1'b1;
      dac_word = w;
      tick(1);
      check_flag(load_o, 1'b1, "output load");
      check_word({4'h0, dacd_o}, {4'h0, w[15:4]}, "output data");
    end
    dac_wr = 1'b0;
    tick(1);
    check_flag(load_o, 1'b0, "output idle");
    $display("test output words done");
    stall = 1'b1;
    taken = 0;
    ok = 1'b1;
    while (ok && taken < 40) begin
      do_access(taken[1:0], ok);
      if (ok) taken++;
    end
    check_flag(taken >= 16, 1'b1, "buffer depth");
    stall = 1'b0;
    for (int i = 0; i < 400 && expq.size() > 0; i++) tick(1);
    tick(4);
    check_flag(expq.size() == 0, 1'b1, "buffer drained");
    $display("test buffer fill and drain done");
    report_and_stop();
  end
endmodule
